// >>> hdl/lane_setup_defs.svh
/*
 * Offsets, PHY slot indices, field positions and reset values of the Type-C lane setup block.
 * Assumes byte addressing on the register bus, one 32-bit word per register.
 */
`ifndef LANE_SETUP_DEFS_SVH
`define LANE_SETUP_DEFS_SVH

// register byte offsets
`define OFS_PIN_ASSIGN      9'h000
`define OFS_LIVE_STATE      9'h004
`define OFS_PORT_BUF        9'h008
`define OFS_LANES_EN        9'h00C
`define OFS_HS_REQ          9'h010
`define OFS_HS_STATE        9'h014
`define OFS_TX_SEL0         9'h018
`define OFS_TX_SEL1         9'h01C
`define OFS_STATUS          9'h020
`define OFS_PHY_BASE        9'h100

// PHY window slot index: {lane, transmitter, register}
`define SLOT_LINK_PARAMS    4'h0
`define SLOT_SWING          4'h1
`define SLOT_DRIVE          4'h2
`define SLOT_CLOCK_HUB      4'h3
`define SLOT_DUTY_CORR      4'h4
`define SLOT_SER_LOAD       4'h5
`define SLOT_RX_DETECT      4'h6
`define SLOT_OBSERVE        4'h7
`define SLOT_RESIST_COMP    4'h8

// field positions
`define CURSOR_HI           11
`define CURSOR_LO           6
`define PRE_HI              5
`define PRE_LO              0
`define POST_HI             17
`define POST_LO             12
`define CAL_INIT_BIT        0
`define DUAL_BIT            1
`define SINGLE_BIT          0
`define BUF_ENABLE_BIT      0

// reset values
`define RST_WORD            32'h0000_0000
`define RST_SEL             2'h0
`define RST_NIBBLE          4'h0
`endif

// >>> hdl/lane_setup_pkg.sv
/*
 * Types of the Type-C lane setup block.
 * Assumes lane_setup_defs.svh is included first.
 */
`include "lane_setup_defs.svh"

package lane_setup_pkg;
    // bus answer sequence, gray coded from BUS_IDLE through BUS_FETCH to BUS_ANSWER
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_FETCH  = 2'b01,
        BUS_ANSWER = 2'b11
    } bus_state_e;

    typedef struct packed {
        bus_state_e  bus_state;
        logic        waitrequest;
        logic [31:0] readdata;
        logic [15:0] pin_assign;
        logic [19:0] live_state;
        logic [3:0]  port_buf;
        logic [2:0]  lanes_enabled;
        logic [3:0]  hs_req;
        logic [3:0]  hs_state;
        logic [1:0]  sel0;
        logic [1:0]  sel1;
        logic [3:0]  cal_pending;
        logic [3:0]  cal_start;
        logic        phy_wr;
        logic [5:0]  phy_addr;
        logic [31:0] phy_wdata;
        logic [5:0]  cursor;
        logic [5:0]  pre_cursor;
        logic [5:0]  post_cursor;
        logic [1:0]  primary_en;
        logic [1:0]  secondary_en;
        logic [1:0]  lane_enable;
        logic        phy_power_on;
        logic        port_active;
    } setup_s;
endpackage

// >>> hdl/phy_shadow_mem.sv
/*
 * Shadow memory of the PHY per-lane, per-transmitter settings.
 * Assumes a single writer; read data come out of a register one cycle later.
 */
`timescale 1ns/10ps

module phy_shadow_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [3:0]       byte_en,
    output logic      [WIDTH-1:0] rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] words;
        logic [WIDTH-1:0]            rdata;
    } mem_s;

    mem_s state;
    mem_s next_state;

    // ==========================================================
    // byte-lane write and registered read
    always_comb begin
        next_state = state;
        next_state.rdata = state.words[addr];
        if (wr_en) begin
            for (int b = 0; b < WIDTH / 8; b++) begin
                if (byte_en[b]) begin
                    next_state.words[addr][b*8 +: 8] = wdata[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;
endmodule

// >>> hdl/typec_phy_lane_setup.sv
/*
 * Type-C PHY lane setup: Avalon-MM register file, PHY setting shadow with
 * write forwarding, calibration load handshake, transmitter select decode,
 * lane shutdown and connector ownership handshake.
 * Assumes synchronous inputs on mclk and a PHY that acknowledges calibration.
 */
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps

module typec_phy_lane_setup
    import lane_setup_pkg::*;
#(
    parameter int PORT_NUM = 1
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [8:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic [3:0]  cal_done,
    output logic      [3:0]  cal_start,
    output logic             phy_wr,
    output logic      [5:0]  phy_addr,
    output logic      [31:0] phy_wdata,
    output logic      [5:0]  deemph_cursor,
    output logic      [5:0]  deemph_pre,
    output logic      [5:0]  deemph_post,
    output logic      [1:0]  primary_tx_en,
    output logic      [1:0]  secondary_tx_en,
    output logic      [1:0]  lane_enable,
    output logic             phy_power_on,
    output logic             port_active
);
    localparam logic [1:0] CONN = 2'(PORT_NUM - 1);

    setup_s      state;
    setup_s      next_state;
    logic [31:0] mem_rdata;
    logic        in_window;
    logic        commit;
    logic        mem_wr;
    logic [5:0]  slot;

    // ==========================================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // select decode, returns {secondary, primary}
    function automatic logic [1:0] tx_decode(input logic [1:0] sel);
        logic [1:0] r;
        r = 2'h1;
        if (sel[`DUAL_BIT]) begin
            r = 2'h3;
        end else if (sel[`SINGLE_BIT]) begin
            r = 2'h2;
        end
        return r;
    endfunction

    // ==========================================================
    // address decode
    assign in_window = address >= `OFS_PHY_BASE;
    assign slot      = address[7:2];
    assign commit    = state.bus_state == BUS_ANSWER && (read || write);
    assign mem_wr    = commit && write && in_window;

    phy_shadow_mem #(
        .WIDTH (32),
        .DEPTH (64),
        .AW    (6)
    ) shadow (
        .mclk    (mclk),
        .reset   (reset),
        .wr_en   (mem_wr),
        .addr    (slot),
        .wdata   (writedata),
        .byte_en (byteenable),
        .rdata   (mem_rdata)
    );

    // ==========================================================
    // next state
    always_comb begin
        logic [31:0] w;
        logic [1:0]  d0;
        logic [1:0]  d1;
        logic        granted;
        w = 32'h0;
        d0 = 2'h0;
        d1 = 2'h0;
        granted = 1'b0;
        next_state = state;
        next_state.phy_wr = 1'b0;
        next_state.cal_start = 4'h0;

        // bus answer sequence
        case (state.bus_state)
            BUS_IDLE: begin
                if (read || write) begin
                    next_state.bus_state = BUS_FETCH;
                end
            end
            BUS_FETCH: begin
                next_state.bus_state = BUS_ANSWER;
                next_state.waitrequest = 1'b0;
                next_state.readdata = 32'h0;
                if (in_window) begin
                    next_state.readdata = mem_rdata;
                    if (slot[3:0] == `SLOT_SER_LOAD) begin
                        next_state.readdata[`CAL_INIT_BIT] = state.cal_pending[slot[5:4]];
                    end
                end else begin
                    case (address)
                        `OFS_PIN_ASSIGN: next_state.readdata = {16'h0, state.pin_assign};
                        `OFS_LIVE_STATE: next_state.readdata = {12'h0, state.live_state};
                        `OFS_PORT_BUF:   next_state.readdata = {28'h0, state.port_buf};
                        `OFS_LANES_EN:   next_state.readdata = {29'h0, state.lanes_enabled};
                        `OFS_HS_REQ:     next_state.readdata = {28'h0, state.hs_req};
                        `OFS_HS_STATE:   next_state.readdata = {28'h0, state.hs_state};
                        `OFS_TX_SEL0:    next_state.readdata = {30'h0, state.sel0};
                        `OFS_TX_SEL1:    next_state.readdata = {30'h0, state.sel1};
                        `OFS_STATUS:     next_state.readdata = {24'h0, state.port_active,
                                                                state.lane_enable,
                                                                state.cal_pending,
                                                                state.phy_power_on};
                        default:         next_state.readdata = 32'h0;
                    endcase
                end
            end
            BUS_ANSWER: begin
                next_state.bus_state = BUS_IDLE;
                next_state.waitrequest = 1'b1;
            end
            default: begin
                next_state.bus_state = BUS_IDLE;
                next_state.waitrequest = 1'b1;
            end
        endcase

        // calibration load clears itself once the PHY takes it
        next_state.cal_pending = state.cal_pending & ~cal_done;

        // register writes take effect at the accepting edge
        if (commit && write) begin
            if (in_window) begin
                w = merge(mem_rdata, writedata, byteenable);
                next_state.phy_wr = 1'b1;
                next_state.phy_addr = slot;
                next_state.phy_wdata = w;
                if (slot[3:0] == `SLOT_DRIVE) begin
                    next_state.cursor = w[`CURSOR_HI:`CURSOR_LO];
                    next_state.pre_cursor = w[`PRE_HI:`PRE_LO];
                end
                if (slot[3:0] == `SLOT_SWING) begin
                    next_state.post_cursor = w[`POST_HI:`POST_LO];
                end
                if (slot[3:0] == `SLOT_SER_LOAD && w[`CAL_INIT_BIT]) begin
                    next_state.cal_pending[slot[5:4]] = 1'b1;
                    next_state.cal_start[slot[5:4]] = 1'b1;
                end
            end else begin
                case (address)
                    `OFS_PIN_ASSIGN: begin
                        w = merge({16'h0, state.pin_assign}, writedata, byteenable);
                        next_state.pin_assign = w[15:0];
                    end
                    `OFS_LIVE_STATE: begin
                        w = merge({12'h0, state.live_state}, writedata, byteenable);
                        next_state.live_state = w[19:0];
                    end
                    `OFS_PORT_BUF: begin
                        if (byteenable[0]) begin
                            next_state.port_buf = writedata[3:0];
                        end
                    end
                    `OFS_LANES_EN: begin
                        if (byteenable[0]) begin
                            next_state.lanes_enabled = writedata[2:0];
                        end
                    end
                    `OFS_HS_REQ: begin
                        if (byteenable[0]) begin
                            next_state.hs_req = writedata[3:0];
                        end
                    end
                    `OFS_TX_SEL0: begin
                        if (byteenable[0]) begin
                            next_state.sel0 = writedata[1:0];
                        end
                    end
                    `OFS_TX_SEL1: begin
                        if (byteenable[0]) begin
                            next_state.sel1 = writedata[1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // ownership granted only to a requested, live connector
        next_state.hs_state = state.hs_req & state.live_state[19:16];
        granted = state.hs_state[CONN];
        next_state.phy_power_on = granted;

        // transmitter select decode and lane shutdown
        d0 = tx_decode(state.sel0);
        d1 = tx_decode(state.sel1);
        next_state.primary_en = {d1[0], d0[0]} & {2{granted}};
        next_state.secondary_en = {d1[1], d0[1]} & {2{granted}};
        next_state.lane_enable[0] = granted && state.sel0 != 2'h0;
        next_state.lane_enable[1] = granted && state.sel1 != 2'h0;
        if (state.sel0 == 2'h0 && state.sel1 == 2'h0) begin
            next_state.lane_enable = {1'b0, granted};
        end
        next_state.port_active = granted && state.port_buf[`BUF_ENABLE_BIT]
                                 && state.cal_pending == 4'h0;
    end

    // ==========================================================
    // state register
    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= '0;
            state.bus_state <= BUS_IDLE;
            state.waitrequest <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // outputs
    assign readdata        = state.readdata;
    assign waitrequest     = state.waitrequest;
    assign cal_start       = state.cal_start;
    assign phy_wr          = state.phy_wr;
    assign phy_addr        = state.phy_addr;
    assign phy_wdata       = state.phy_wdata;
    assign deemph_cursor   = state.cursor;
    assign deemph_pre      = state.pre_cursor;
    assign deemph_post     = state.post_cursor;
    assign primary_tx_en   = state.primary_en;
    assign secondary_tx_en = state.secondary_en;
    assign lane_enable     = state.lane_enable;
    assign phy_power_on    = state.phy_power_on;
    assign port_active     = state.port_active;

    // ==========================================================
    // checks
    a_cal_self_clear: assert property (@(posedge mclk) disable iff (reset)
        (state.cal_pending[3] && cal_done[3] && !(mem_wr && slot == 6'h35))
        |=> !state.cal_pending[3])
        else $error("calibration load bit did not clear");

    a_cal_start_set: assert property (@(posedge mclk) disable iff (reset)
        (mem_wr && slot == 6'h35 && writedata[0] && byteenable[0])
        |=> cal_start[3] && state.cal_pending[3])
        else $error("calibration start not raised");

    a_cursor_field: assert property (@(posedge mclk) disable iff (reset)
        (mem_wr && slot[3:0] == 4'h2 && byteenable == 4'hF)
        |=> deemph_cursor == $past(writedata[11:6]) && deemph_pre == $past(writedata[5:0]))
        else $error("drive fields not captured");

    a_post_field: assert property (@(posedge mclk) disable iff (reset)
        (mem_wr && slot[3:0] == 4'h1 && byteenable == 4'hF)
        |=> deemph_post == $past(writedata[17:12]))
        else $error("post-cursor not captured");

    a_sel_store: assert property (@(posedge mclk) disable iff (reset)
        (commit && write && address == 9'h01C && byteenable[0])
        |=> state.sel1 == $past(writedata[1:0]))
        else $error("lane select not stored");

    a_dual_both: assert property (@(posedge mclk) disable iff (reset)
        (state.sel0[1] && state.hs_state[CONN]) |=> primary_tx_en[0] && secondary_tx_en[0])
        else $error("dual select did not enable both");

    a_single_only: assert property (@(posedge mclk) disable iff (reset)
        (state.sel1 == 2'h1 && state.hs_state[CONN]) |=> !primary_tx_en[1] && secondary_tx_en[1])
        else $error("single select wrong decode");

    a_lane_off: assert property (@(posedge mclk) disable iff (reset)
        (state.sel1 == 2'h0 && state.hs_state[CONN]) |=> !lane_enable[1])
        else $error("unused lane not shut down");

    a_power_grant: assert property (@(posedge mclk) disable iff (reset)
        (state.hs_req[CONN] && state.live_state[16 + CONN]) |-> ##2 phy_power_on)
        else $error("power not granted after handshake");

    a_port_map: assert property (@(posedge mclk) disable iff (reset)
        phy_power_on |-> $past(state.hs_state[CONN]))
        else $error("power follows wrong connector");
endmodule

// >>> verif/phy_model.sv
/*
 * Behavioural model of the two-lane PHY calibration load handshake.
 * Assumes cal_start pulses per slot (lane*2+tx) on mclk from the setup block.
 */
`timescale 1ns/10ps

module phy_model #(
    parameter int BASE_DLY = 2
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [3:0] cal_start,
    output logic      [3:0] cal_done
);
    logic [7:0] cnt [4];

    // ========================================
    // load acceptance
    // ========================================
    // per slot load delay, later slots answer slower
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (reset) begin
                cnt[i]      <= 8'h00;
                cal_done[i] <= 1'b0;
            end else if (cal_start[i]) begin
                cnt[i]      <= 8'(BASE_DLY + 8 * i);
                cal_done[i] <= 1'b0;
            end else begin
                cnt[i]      <= (cnt[i] != 8'h00) ? cnt[i] - 8'h01 : 8'h00;
                cal_done[i] <= (cnt[i] == 8'h01);
            end
        end
    end
endmodule

// >>> verif/tb.sv
/*
 * Self-checking bench of the Type-C lane setup block over Avalon-MM.
 * Assumes the package and defs header are compiled first, PORT_NUM of 1.
 */
`timescale 1ns/10ps
`include "lane_setup_defs.svh"

module tb;
    import lane_setup_pkg::*;
    logic        mclk, reset, read, write, waitrequest, phy_wr, phy_power_on, port_active;
    logic [8:0]  address;
    logic [31:0] writedata, readdata, phy_wdata, d;
    logic [3:0]  byteenable, cal_done, cal_start;
    logic [5:0]  phy_addr, deemph_cursor, deemph_pre, deemph_post, idx;
    logic [1:0]  primary_tx_en, secondary_tx_en, lane_enable;
    logic [5:0]  cur [4] = '{6'h26, 6'h21, 6'h3F, 6'h36};
    logic [5:0]  pst [4] = '{6'h00, 6'h00, 6'h00, 6'h09};
    int          error_cnt, cmp_count, cycles, n;

    typec_phy_lane_setup #(.PORT_NUM(1)) DUT (.mclk(mclk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .cal_done(cal_done),
        .cal_start(cal_start), .phy_wr(phy_wr), .phy_addr(phy_addr), .phy_wdata(phy_wdata),
        .deemph_cursor(deemph_cursor), .deemph_pre(deemph_pre), .deemph_post(deemph_post),
        .primary_tx_en(primary_tx_en), .secondary_tx_en(secondary_tx_en),
        .lane_enable(lane_enable), .phy_power_on(phy_power_on), .port_active(port_active));

    phy_model #(.BASE_DLY(2)) phy (.mclk(mclk), .reset(reset), .cal_start(cal_start),
        .cal_done(cal_done));

    // ========================================
    // helpers
    // ========================================
    task automatic complete_run();
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one bus cycle; holds the request until waitrequest is sampled low
    task automatic bus(input logic [8:0] a, input logic wr, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] rd);
        @(posedge mclk);
        address    <= a;
        writedata  <= wd;
        byteenable <= be;
        write      <= wr;
        read       <= !wr;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] wd);
        bus(a, 1'b1, wd, 4'hF, d);
    endtask

    task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0, 4'hF, d);
        check(d, exp);
    endtask

    function automatic logic [8:0] pa(input logic [5:0] i);
        return `OFS_PHY_BASE + {1'b0, i, 2'b00};
    endfunction

    // clock and run limit
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ========================================
    // main sequence
    // ========================================
    initial begin
        {mclk, read, write, address, writedata, byteenable} = '0;
        reset = 1'b1;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        #1 check(32'({waitrequest, phy_power_on, port_active, lane_enable}), 32'h10);
        // ownership needs live state and request of this connector only
        wr(`OFS_PIN_ASSIGN, 32'h0000_0001);
        wr(`OFS_LIVE_STATE, 32'h0001_000F);
        wr(`OFS_HS_REQ, 32'h2);
        rd_chk(`OFS_HS_STATE, 32'h0);
        check(32'(phy_power_on), 32'h0);
        wr(`OFS_HS_REQ, 32'h3);
        wr(`OFS_HS_STATE, 32'hF);
        rd_chk(`OFS_HS_STATE, 32'h1);
        check(32'(phy_power_on), 32'h1);
        // transmitter select decode on lane 0, lane 1 dual
        wr(`OFS_TX_SEL1, 32'h2);
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_TX_SEL0, 32'(c));
            rd_chk(`OFS_TX_SEL0, 32'(c));
            check(32'({primary_tx_en, secondary_tx_en}), 32'({1'b1, c != 1, 1'b1, c != 0}));
            check(32'(lane_enable), 32'({1'b1, c != 0}));
        end
        // select decode: both lanes dual, both single, lane 0 unused, then both unused
        wr(`OFS_LANES_EN, 32'h4);
        rd_chk(`OFS_LANES_EN, 32'h4);
        wr(`OFS_TX_SEL0, 32'h2);
        wr(`OFS_TX_SEL1, 32'h2);
        rd_chk(`OFS_TX_SEL1, 32'h2);
        check(32'({primary_tx_en, secondary_tx_en, lane_enable}), 32'h3F);
        wr(`OFS_PIN_ASSIGN, 32'h0000_0003);
        wr(`OFS_LANES_EN, 32'h1);
        wr(`OFS_TX_SEL0, 32'h1);
        wr(`OFS_TX_SEL1, 32'h1);
        rd_chk(`OFS_TX_SEL1, 32'h1);
        check(32'({primary_tx_en, secondary_tx_en, lane_enable}), 32'h0F);
        wr(`OFS_PIN_ASSIGN, 32'h0000_0000);
        wr(`OFS_TX_SEL0, 32'h0);
        rd_chk(`OFS_TX_SEL0, 32'h0);
        check(32'({primary_tx_en, secondary_tx_en, lane_enable}), 32'h1A);
        wr(`OFS_TX_SEL0, 32'h0);
        wr(`OFS_TX_SEL1, 32'h0);
        rd_chk(`OFS_TX_SEL1, 32'h0);
        check(32'(lane_enable), 32'h1);
        // swing entries over all lanes and transmitters
        for (int i = 0; i < 4; i++) begin
            idx = {i[1], i[0], `SLOT_DRIVE};
            wr(pa({i[1], i[0], `SLOT_LINK_PARAMS}), 32'h0);
            wr(pa({i[1], i[0], `SLOT_SWING}), {14'h0, pst[i], 12'h0});
            wr(pa(idx), {19'h0, 1'b1, cur[i], 6'h00});
            #1 check(32'({phy_wr, phy_addr}), 32'({1'b1, idx}));
            check(phy_wdata, {19'h0, 1'b1, cur[i], 6'h00});
            wr(pa({i[1], i[0], `SLOT_CLOCK_HUB}), 32'h1);
            wr(pa({i[1], i[0], `SLOT_DUTY_CORR}), 32'h0);
            wr(pa({i[1], i[0], `SLOT_RX_DETECT}), 32'h0);
            wr(pa({i[1], i[0], `SLOT_OBSERVE}), 32'hFF);
            wr(pa({i[1], i[0], `SLOT_RESIST_COMP}), i[0] ? 32'hA0A0 : 32'hA5A5);
            rd_chk(pa({i[1], i[0], `SLOT_RESIST_COMP}), i[0] ? 32'hA0A0 : 32'hA5A5);
            rd_chk(pa(idx), {19'h0, 1'b1, cur[i], 6'h00});
            check(32'({deemph_cursor, deemph_pre, deemph_post}), 32'({cur[i], 6'h00, pst[i]}));
        end
        // partial write merges into the stored word
        bus(pa(idx), 1'b1, 32'hFFFF_FFFF, 4'h1, d);
        #1 check(phy_wdata, 32'h0000_1DFF);
        rd_chk(pa(idx), 32'h0000_1DFF);
        // calibration load on the slowest slot
        wr(`OFS_PORT_BUF, 32'h1);
        wr(pa({2'b11, `SLOT_SER_LOAD}), 32'h1);
        #1 check(32'(cal_start), 32'h8);
        rd_chk(pa({2'b11, `SLOT_SER_LOAD}), 32'h1);
        rd_chk(`OFS_STATUS, 32'h31);
        check(32'(port_active), 32'h0);
        n = 0;
        while (port_active !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        rd_chk(pa({2'b11, `SLOT_SER_LOAD}), 32'h0);
        rd_chk(`OFS_STATUS, 32'hA1);
        // unmapped place reads zero and ignores writes
        wr(9'h024, 32'hFFFF_FFFF);
        rd_chk(9'h024, 32'h0);
        // disconnect hands ownership back
        wr(`OFS_PORT_BUF, 32'h0);
        wr(`OFS_HS_REQ, 32'h0);
        rd_chk(`OFS_HS_STATE, 32'h0);
        check(32'({phy_power_on, port_active, primary_tx_en}), 32'h0);
        complete_run();
    end
endmodule
